//--- rtl/cmpx_pkg.sv
// package: register map, field layout and codes of the comparator control block
package cmpx_pkg;
  // register indices (byte addresses, plain 3-bit space)
  localparam logic [2:0] CMPX_ADR_C1MAIN = 3'h0;
  localparam logic [2:0] CMPX_ADR_C1IN = 3'h1;
  localparam logic [2:0] CMPX_ADR_C2MAIN = 3'h2;
  localparam logic [2:0] CMPX_ADR_C2IN = 3'h3;
  localparam logic [2:0] CMPX_ADR_MIRROR = 3'h4;
  localparam logic [2:0] CMPX_ADR_STATUS = 3'h5;
  localparam logic [2:0] CMPX_ADR_MASK = 3'h6;
  localparam int CMPX_AW = 3;
  localparam int CMPX_DW = 8;
  localparam int CMPX_NCMP = 2;
  // main control: bit 4 polarity, bit 6 result (read only)
  localparam int CMPX_MAIN_POL = 4;
  localparam int CMPX_MAIN_OUT = 6;
  // inputs control
  localparam int CMPX_IN_RISE = 7;
  localparam int CMPX_IN_FALL = 6;
  localparam int CMPX_IN_PSEL_LO = 4;
  localparam int CMPX_IN_NSEL_LO = 0;
  // writable bit masks (bits 3-2 of inputs control unimplemented)
  localparam logic [7:0] CMPX_IN_WMASK = 8'hf3;
  localparam logic [7:0] CMPX_MAIN_WMASK = 8'h10;
  localparam logic [7:0] CMPX_RST_BYTE = 8'h00;
  // plus input select codes
  localparam logic [1:0] CMPX_P_PIN = 2'h0;
  localparam logic [1:0] CMPX_P_DAC = 2'h1;
  localparam logic [1:0] CMPX_P_FIXREF = 2'h2;
  localparam logic [1:0] CMPX_P_ALT = 2'h3;
  // one-hot route of the noninverting node: pin, dac, fixed reference
  localparam logic [2:0] CMPX_ROUTE_PIN = 3'h1;
  localparam logic [2:0] CMPX_ROUTE_DAC = 3'h2;
  localparam logic [2:0] CMPX_ROUTE_FIXREF = 3'h4;
  localparam logic [2:0] CMPX_ROUTE_NONE = 3'h0;
  // edge tracker states
  typedef enum logic [2:0] {
    CMPX_ST_INIT = 3'h1,
    CMPX_ST_LOW = 3'h2,
    CMPX_ST_HIGH = 3'h4
  } cmpx_edge_st_t;
endpackage

//--- rtl/cmpx_edge.sv
// edge tracker: turns a result bit into rise and fall pulses
`timescale 1ns/1ps
module cmpx_edge
  import cmpx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    cmpx_edge_st_t st;
  } cmpx_edge_state_t;
  cmpx_edge_state_t s_ff;
  cmpx_edge_state_t nxt_s;

  // first sample after reset only seeds the state, so no false edge
  always_comb
  begin
    nxt_s = s_ff;
    rise = 1'b0;
    fall = 1'b0;
    case (s_ff.st)
      CMPX_ST_INIT: nxt_s.st = level ? CMPX_ST_HIGH : CMPX_ST_LOW;
      CMPX_ST_LOW:
      begin
        if (level)
        begin
          rise = 1'b1;
          nxt_s.st = CMPX_ST_HIGH;
        end
      end
      CMPX_ST_HIGH:
      begin
        if (!level)
        begin
          fall = 1'b1;
          nxt_s.st = CMPX_ST_LOW;
        end
      end
      default: nxt_s.st = CMPX_ST_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= '{st: CMPX_ST_INIT};
    else
      s_ff <= nxt_s;
  end
endmodule

//--- rtl/cmpx_route.sv
// input routing decode for one comparator
`timescale 1ns/1ps
module cmpx_route
  import cmpx_pkg::*;
(
  input wire logic [1:0] plus_input_select,
  input wire logic [1:0] minus_input_select,
  input wire logic alt_is_pin,
  output logic [2:0] noninverting_node,
  output logic [3:0] inverting_node
);
  always_comb
  begin
    case (plus_input_select)
      CMPX_P_PIN: noninverting_node = CMPX_ROUTE_PIN;
      CMPX_P_DAC: noninverting_node = CMPX_ROUTE_DAC;
      CMPX_P_FIXREF: noninverting_node = CMPX_ROUTE_FIXREF;
      // code 11 on the second unit is left unconnected
      CMPX_P_ALT: noninverting_node = alt_is_pin ? CMPX_ROUTE_PIN : CMPX_ROUTE_NONE;
      default: noninverting_node = CMPX_ROUTE_NONE;
    endcase
    inverting_node = 4'h0;
    inverting_node[minus_input_select] = 1'b1;
  end
endmodule

//--- rtl/cmpx_top.sv
// comparator control: input select, polarity, edge flags, output mirror
// Functional notes
// - fall enable set means high-to-low result transition sets the irq flag.
// - plus select 00 pin, 01 dac reference, 10 fixed reference.
// - first comparator plus select 11 also routes the external pin.
// - minus select bits 1-0 choose shared minus pin 0 to 3.
// - mirror register bit 1 second result, bit 0 first, zero after reset.
// - mirror bits 7-2 and inputs-control bits 3-2 read zero, ignore writes.
// - polarity bit set inverts the raw comparator result.
`timescale 1ns/1ps
module cmpx_top
  import cmpx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CMPX_AW-1:0] reg_addr,
  input wire logic [CMPX_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [CMPX_DW-1:0] reg_rdata,
  input wire logic [CMPX_NCMP-1:0] raw_result,
  output logic [1:0] plus_input_select_1,
  output logic [1:0] plus_input_select_2,
  output logic [2:0] noninverting_node_1,
  output logic [2:0] noninverting_node_2,
  output logic [3:0] inverting_node_1,
  output logic [3:0] inverting_node_2,
  output logic [CMPX_NCMP-1:0] comparator_result_bit,
  output logic irq
);
  typedef struct packed {
    logic [CMPX_NCMP-1:0] pol;
    logic [CMPX_NCMP-1:0] rise_en;
    logic [CMPX_NCMP-1:0] fall_en;
    logic [1:0] psel1;
    logic [1:0] psel2;
    logic [1:0] nsel1;
    logic [1:0] nsel2;
    logic [CMPX_NCMP-1:0] res;
    logic [CMPX_NCMP-1:0] flag;
    logic [CMPX_NCMP-1:0] mask;
    logic [CMPX_DW-1:0] rdata;
  } cmpx_state_t;

  cmpx_state_t s_ff;
  cmpx_state_t nxt_s;
  logic [CMPX_NCMP-1:0] rise_p;
  logic [CMPX_NCMP-1:0] fall_p;
  logic [CMPX_NCMP-1:0] edge_set;

  function automatic logic [CMPX_DW-1:0] cmpx_in_byte(input logic re, input logic fe,
                                                      input logic [1:0] ps, input logic [1:0] ns);
    logic [CMPX_DW-1:0] b;
    b = CMPX_RST_BYTE;
    b[CMPX_IN_RISE] = re;
    b[CMPX_IN_FALL] = fe;
    b[CMPX_IN_PSEL_LO +: 2] = ps;
    b[CMPX_IN_NSEL_LO +: 2] = ns;
    return b & CMPX_IN_WMASK;
  endfunction

  function automatic logic [CMPX_DW-1:0] cmpx_main_byte(input logic pol, input logic res);
    logic [CMPX_DW-1:0] b;
    b = CMPX_RST_BYTE;
    b[CMPX_MAIN_POL] = pol;
    b[CMPX_MAIN_OUT] = res;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge trackers on the polarity-corrected result
  for (genvar i = 0; i < CMPX_NCMP; i++)
  begin : g_edge
    cmpx_edge u_edge (
      .clk(clk),
      .rst_n(rst_n),
      .level(s_ff.res[i]),
      .rise(rise_p[i]),
      .fall(fall_p[i])
    );
  end

  assign edge_set = (rise_p & s_ff.rise_en) | (fall_p & s_ff.fall_en);

  ////////////////////////////////////////////////////////////////////////////
  // routing decode
  cmpx_route u_route1 (
    .plus_input_select(s_ff.psel1),
    .minus_input_select(s_ff.nsel1),
    .alt_is_pin(1'b1),
    .noninverting_node(noninverting_node_1),
    .inverting_node(inverting_node_1)
  );

  cmpx_route u_route2 (
    .plus_input_select(s_ff.psel2),
    .minus_input_select(s_ff.nsel2),
    .alt_is_pin(1'b0),
    .noninverting_node(noninverting_node_2),
    .inverting_node(inverting_node_2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.res = raw_result ^ s_ff.pol;
    if (reg_wr)
    begin
      case (reg_addr)
        CMPX_ADR_C1MAIN: nxt_s.pol[0] = reg_wdata[CMPX_MAIN_POL];
        CMPX_ADR_C2MAIN: nxt_s.pol[1] = reg_wdata[CMPX_MAIN_POL];
        CMPX_ADR_C1IN:
        begin
          nxt_s.rise_en[0] = reg_wdata[CMPX_IN_RISE];
          nxt_s.fall_en[0] = reg_wdata[CMPX_IN_FALL];
          nxt_s.psel1 = reg_wdata[CMPX_IN_PSEL_LO +: 2];
          nxt_s.nsel1 = reg_wdata[CMPX_IN_NSEL_LO +: 2];
        end
        CMPX_ADR_C2IN:
        begin
          nxt_s.rise_en[1] = reg_wdata[CMPX_IN_RISE];
          nxt_s.fall_en[1] = reg_wdata[CMPX_IN_FALL];
          nxt_s.psel2 = reg_wdata[CMPX_IN_PSEL_LO +: 2];
          nxt_s.nsel2 = reg_wdata[CMPX_IN_NSEL_LO +: 2];
        end
        CMPX_ADR_STATUS: nxt_s.flag = s_ff.flag & ~reg_wdata[CMPX_NCMP-1:0];
        CMPX_ADR_MASK: nxt_s.mask = reg_wdata[CMPX_NCMP-1:0];
        default: nxt_s.flag = s_ff.flag; // mirror and unmapped writes ignored
      endcase
    end
    // set beats a same-cycle write-one clear
    nxt_s.flag = nxt_s.flag | edge_set;
    nxt_s.rdata = CMPX_RST_BYTE;
    if (reg_rd)
    begin
      case (reg_addr)
        CMPX_ADR_C1MAIN: nxt_s.rdata = cmpx_main_byte(s_ff.pol[0], s_ff.res[0]);
        CMPX_ADR_C2MAIN: nxt_s.rdata = cmpx_main_byte(s_ff.pol[1], s_ff.res[1]);
        CMPX_ADR_C1IN:
          nxt_s.rdata = cmpx_in_byte(s_ff.rise_en[0], s_ff.fall_en[0], s_ff.psel1, s_ff.nsel1);
        CMPX_ADR_C2IN:
          nxt_s.rdata = cmpx_in_byte(s_ff.rise_en[1], s_ff.fall_en[1], s_ff.psel2, s_ff.nsel2);
        CMPX_ADR_MIRROR: nxt_s.rdata = {{(CMPX_DW-CMPX_NCMP){1'b0}}, s_ff.res};
        CMPX_ADR_STATUS: nxt_s.rdata = {{(CMPX_DW-CMPX_NCMP){1'b0}}, s_ff.flag};
        CMPX_ADR_MASK: nxt_s.rdata = {{(CMPX_DW-CMPX_NCMP){1'b0}}, s_ff.mask};
        default: nxt_s.rdata = CMPX_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign reg_rdata = s_ff.rdata;
  assign comparator_result_bit = s_ff.res;
  assign plus_input_select_1 = s_ff.psel1;
  assign plus_input_select_2 = s_ff.psel2;
  assign irq = |(s_ff.flag & s_ff.mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_rise_sets;
    @(posedge clk) disable iff (!rst_n)
      (rise_p[0] && s_ff.rise_en[0]) |=> s_ff.flag[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise did not set flag");

  property p_rise_quiet;
    @(posedge clk) disable iff (!rst_n)
      (!s_ff.flag[1] && rise_p[1] && !s_ff.rise_en[1] && !fall_p[1]) |=> !s_ff.flag[1];
  endproperty
  a_rise_quiet: assert property (p_rise_quiet) else $error("disabled rise set flag");

  property p_fall_sets;
    @(posedge clk) disable iff (!rst_n)
      (fall_p[1] && s_ff.fall_en[1]) |=> s_ff.flag[1];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall did not set flag");

  property p_fall_quiet;
    @(posedge clk) disable iff (!rst_n)
      (!s_ff.flag[0] && fall_p[0] && !s_ff.fall_en[0]) |=> !s_ff.flag[0];
  endproperty
  a_fall_quiet: assert property (p_fall_quiet) else $error("disabled fall set flag");

  property p_plus_route;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.psel2 == CMPX_P_FIXREF) |-> (noninverting_node_2 == CMPX_ROUTE_FIXREF);
  endproperty
  a_plus_route: assert property (p_plus_route) else $error("plus route wrong");

  property p_alt_pin;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.psel1 == CMPX_P_ALT) |-> (noninverting_node_1 == CMPX_ROUTE_PIN);
  endproperty
  a_alt_pin: assert property (p_alt_pin) else $error("code 11 not routed to pin");

  property p_minus_route;
    @(posedge clk) disable iff (!rst_n)
      $onehot(inverting_node_1) && inverting_node_1[s_ff.nsel1];
  endproperty
  a_minus_route: assert property (p_minus_route) else $error("minus route wrong");

  property p_mirror;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == CMPX_ADR_MIRROR) |=>
        (reg_rdata == {{(CMPX_DW-CMPX_NCMP){1'b0}}, $past(s_ff.res)});
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror read wrong");

  property p_unimpl;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && (reg_addr == CMPX_ADR_C1IN || reg_addr == CMPX_ADR_C2IN)) |=>
        (reg_rdata[3:2] == 2'h0);
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero");

  // the edge that releases reset still loads zero, so skip that one
  property p_polarity;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> (comparator_result_bit == ($past(raw_result) ^ $past(s_ff.pol)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied");

  property p_rise_sets_2;
    @(posedge clk) disable iff (!rst_n)
      (rise_p[1] && s_ff.rise_en[1]) |=> s_ff.flag[1];
  endproperty
  a_rise_sets_2: assert property (p_rise_sets_2) else $error("rise did not set flag 2");

  property p_rise_quiet_1;
    @(posedge clk) disable iff (!rst_n)
      (!s_ff.flag[0] && rise_p[0] && !s_ff.rise_en[0]) |=> !s_ff.flag[0];
  endproperty
  a_rise_quiet_1: assert property (p_rise_quiet_1) else $error("disabled rise set flag 1");

  property p_fall_sets_1;
    @(posedge clk) disable iff (!rst_n)
      (fall_p[0] && s_ff.fall_en[0]) |=> s_ff.flag[0];
  endproperty
  a_fall_sets_1: assert property (p_fall_sets_1) else $error("fall did not set flag 1");

  property p_fall_quiet_2;
    @(posedge clk) disable iff (!rst_n)
      (!s_ff.flag[1] && fall_p[1] && !s_ff.fall_en[1]) |=> !s_ff.flag[1];
  endproperty
  a_fall_quiet_2: assert property (p_fall_quiet_2) else $error("disabled fall set flag 2");

  property p_plus_pin_1;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.psel1 == CMPX_P_PIN) |-> (noninverting_node_1 == CMPX_ROUTE_PIN);
  endproperty
  a_plus_pin_1: assert property (p_plus_pin_1) else $error("plus pin route 1 wrong");

  property p_plus_dac_1;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.psel1 == CMPX_P_DAC) |-> (noninverting_node_1 == CMPX_ROUTE_DAC);
  endproperty
  a_plus_dac_1: assert property (p_plus_dac_1) else $error("plus dac route 1 wrong");

  property p_plus_fix_1;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.psel1 == CMPX_P_FIXREF) |-> (noninverting_node_1 == CMPX_ROUTE_FIXREF);
  endproperty
  a_plus_fix_1: assert property (p_plus_fix_1) else $error("plus ref route 1 wrong");

  property p_plus_pin_2;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.psel2 == CMPX_P_PIN) |-> (noninverting_node_2 == CMPX_ROUTE_PIN);
  endproperty
  a_plus_pin_2: assert property (p_plus_pin_2) else $error("plus pin route 2 wrong");

  property p_minus_route_2;
    @(posedge clk) disable iff (!rst_n)
      $onehot(inverting_node_2) && inverting_node_2[s_ff.nsel2];
  endproperty
  a_minus_route_2: assert property (p_minus_route_2) else $error("minus route 2 wrong");

  property p_psel_store_1;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == CMPX_ADR_C1IN) |=>
        (plus_input_select_1 == $past(reg_wdata[CMPX_IN_PSEL_LO +: 2]));
  endproperty
  a_psel_store_1: assert property (p_psel_store_1) else $error("plus select 1 not stored");

  property p_psel_store_2;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == CMPX_ADR_C2IN) |=>
        (plus_input_select_2 == $past(reg_wdata[CMPX_IN_PSEL_LO +: 2]));
  endproperty
  a_psel_store_2: assert property (p_psel_store_2) else $error("plus select 2 not stored");

  property p_flag_hold_1;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.flag[0] && !(reg_wr && reg_addr == CMPX_ADR_STATUS && reg_wdata[0])) |=> s_ff.flag[0];
  endproperty
  a_flag_hold_1: assert property (p_flag_hold_1) else $error("flag 1 dropped");

  property p_flag_hold_2;
    @(posedge clk) disable iff (!rst_n)
      (s_ff.flag[1] && !(reg_wr && reg_addr == CMPX_ADR_STATUS && reg_wdata[1])) |=> s_ff.flag[1];
  endproperty
  a_flag_hold_2: assert property (p_flag_hold_2) else $error("flag 2 dropped");

  property p_flag_clear_1;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == CMPX_ADR_STATUS && reg_wdata[0] && !edge_set[0]) |=> !s_ff.flag[0];
  endproperty
  a_flag_clear_1: assert property (p_flag_clear_1) else $error("flag 1 not cleared");

  property p_set_wins_1;
    @(posedge clk) disable iff (!rst_n)
      (edge_set[0] && reg_wr && reg_addr == CMPX_ADR_STATUS && reg_wdata[0]) |=> s_ff.flag[0];
  endproperty
  a_set_wins_1: assert property (p_set_wins_1) else $error("clear beat set on 1");

  property p_set_wins_2;
    @(posedge clk) disable iff (!rst_n)
      (edge_set[1] && reg_wr && reg_addr == CMPX_ADR_STATUS && reg_wdata[1]) |=> s_ff.flag[1];
  endproperty
  a_set_wins_2: assert property (p_set_wins_2) else $error("clear beat set on 2");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_n)
      !reg_rd |=> (reg_rdata == CMPX_RST_BYTE);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_mirror_ignore;
    @(posedge clk) disable iff (!rst_n)
      (reg_wr && reg_addr == CMPX_ADR_MIRROR) |=>
        ($stable(s_ff.pol) && $stable(s_ff.mask) && $stable(s_ff.rise_en) && $stable(s_ff.fall_en)
         && $stable(s_ff.psel1) && $stable(s_ff.psel2) && $stable(s_ff.nsel1) && $stable(s_ff.nsel2));
  endproperty
  a_mirror_ignore: assert property (p_mirror_ignore) else $error("mirror write took effect");

  property p_main_read_1;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == CMPX_ADR_C1MAIN) |=>
        (reg_rdata[CMPX_MAIN_OUT] == $past(comparator_result_bit[0]));
  endproperty
  a_main_read_1: assert property (p_main_read_1) else $error("result 1 read wrong");

  property p_main_read_2;
    @(posedge clk) disable iff (!rst_n)
      (reg_rd && reg_addr == CMPX_ADR_C2MAIN) |=>
        (reg_rdata[CMPX_MAIN_OUT] == $past(comparator_result_bit[1]));
  endproperty
  a_main_read_2: assert property (p_main_read_2) else $error("result 2 read wrong");
endmodule

//--- verification/cmpx_analog_model.sv
// behavioural model of the two analog comparator cores and their input multiplexers
`timescale 1ns/1ps
module cmpx_analog_model
(
  input wire logic clk,
  input wire logic [2:0] noninverting_node_1,
  input wire logic [2:0] noninverting_node_2,
  input wire logic [3:0] inverting_node_1,
  input wire logic [3:0] inverting_node_2,
  input wire logic [1:0][7:0] v_pin,
  input wire logic [1:0][7:0] v_ref,
  input wire logic [3:0][7:0] v_min,
  output logic [1:0] raw_result
);
  // unrouted node reads as ground, so that comparator reports low
  function automatic logic [7:0] sel_plus(logic [2:0] r, logic [7:0] pin);
    sel_plus = r[0] ? pin : r[1] ? v_ref[0] : r[2] ? v_ref[1] : 8'h00;
  endfunction

  function automatic logic [7:0] sel_minus(logic [3:0] r);
    sel_minus = 8'h00;
    for (int i = 0; i < 4; i++)
      if (r[i])
        sel_minus = v_min[i];
  endfunction

  // result is settled to the clock, as the block expects
  always_ff @(posedge clk)
  begin
    raw_result[0] <= sel_plus(noninverting_node_1, v_pin[0]) > sel_minus(inverting_node_1);
    raw_result[1] <= sel_plus(noninverting_node_2, v_pin[1]) > sel_minus(inverting_node_2);
  end
endmodule

//--- verification/test_cmpx_top.sv
// self-checking bench of the comparator control block
`timescale 1ns/1ps
module test_cmpx_top
  import cmpx_pkg::*;
;
  logic clk, rst_n, reg_wr, reg_rd, irq;
  logic [2:0] reg_addr, noninverting_node_1, noninverting_node_2;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [1:0] raw_result, plus_input_select_1, plus_input_select_2;
  logic [1:0] comparator_result_bit, pol, res;
  logic [3:0] inverting_node_1, inverting_node_2;
  logic [1:0][7:0] v_pin, v_ref;
  logic [3:0][7:0] v_min;
  int num_errors, compares;

  cmpx_top u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .raw_result, .plus_input_select_1, .plus_input_select_2, .noninverting_node_1,
    .noninverting_node_2, .inverting_node_1, .inverting_node_2, .comparator_result_bit, .irq);
  cmpx_analog_model u_ana (.clk, .noninverting_node_1, .noninverting_node_2,
    .inverting_node_1, .inverting_node_2, .v_pin, .v_ref, .v_min, .raw_result);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // idle cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [2:0] a, input logic [7:0] dat);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, "read");
    tick(1);
  endtask

  function automatic logic [2:0] exp_route(input logic [1:0] p, input logic first);
    case (p)
      2'h0: exp_route = CMPX_ROUTE_PIN;
      2'h1: exp_route = CMPX_ROUTE_DAC;
      2'h2: exp_route = CMPX_ROUTE_FIXREF;
      default: exp_route = first ? CMPX_ROUTE_PIN : CMPX_ROUTE_NONE;
    endcase
  endfunction

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    tick(20000);
    num_errors++;
    test_done();
  end

  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    v_pin = 16'h0000;
    v_ref = 16'h40c0;
    v_min = 32'h80808080;
    num_errors = 0;
    compares = 0;
    void'($urandom(32'h0e422b93));
    tick(3);
    rst_n <= 1'b1;
    tick(1);
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00);
    check(8'(noninverting_node_1), 8'(CMPX_ROUTE_PIN), "reset route");
    for (int i = 0; i < 16; i++)
    begin
      d = {2'($urandom), i[3:2], 2'b11, i[1:0]};
      wr(CMPX_ADR_C1IN, d);
      wr(CMPX_ADR_C2IN, d);
      rd(CMPX_ADR_C1IN, d & 8'hf3);
      rd(CMPX_ADR_C2IN, d & 8'hf3);
      check(8'(noninverting_node_1), 8'(exp_route(i[3:2], 1'b1)), "route1");
      check(8'(noninverting_node_2), 8'(exp_route(i[3:2], 1'b0)), "route2");
      check(8'(inverting_node_2), 8'(4'h1 << i[1:0]), "minus");
      check(8'(inverting_node_1), 8'(4'h1 << i[1:0]), "minus1");
      check(8'(plus_input_select_2), 8'(i[3:2]), "psel2");
      check(8'(plus_input_select_1), 8'(i[3:2]), "psel");
    end
    wr(CMPX_ADR_C1IN, 8'h00);
    wr(CMPX_ADR_C2IN, 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      pol = 2'($urandom);
      v_pin <= 16'($urandom);
      v_min[0] <= 8'($urandom);
      wr(CMPX_ADR_C1MAIN, {3'($urandom), pol[0], 4'($urandom)});
      wr(CMPX_ADR_C2MAIN, {3'($urandom), pol[1], 4'($urandom)});
      wr(CMPX_ADR_MIRROR, 8'hff);
      wr(3'h7, 8'hff);
      res = {v_pin[1] > v_min[0], v_pin[0] > v_min[0]} ^ pol;
      check(8'(comparator_result_bit), 8'(res), "result");
      rd(CMPX_ADR_MIRROR, {6'h00, res});
      rd(3'h7, 8'h00);
      rd(CMPX_ADR_C1MAIN, {1'b0, res[0], 1'b0, pol[0], 4'h0});
      rd(CMPX_ADR_C2MAIN, {1'b0, res[1], 1'b0, pol[1], 4'h0});
    end
    wr(CMPX_ADR_C1MAIN, 8'h00);
    wr(CMPX_ADR_C2MAIN, 8'h00);
    // second comparator masked: its flag must not reach irq
    wr(CMPX_ADR_MASK, 8'h01);
    v_min[0] <= 8'h80;
    for (int e = 0; e < 4; e++)
    begin
      v_pin <= 16'h1010;
      wr(CMPX_ADR_C1IN, {e[1:0], 6'h00});
      wr(CMPX_ADR_C2IN, {e[1:0], 6'h00});
      tick(4);
      wr(CMPX_ADR_STATUS, 8'h03);
      v_pin <= 16'hf0f0;
      tick(5);
      rd(CMPX_ADR_STATUS, e[1] ? 8'h03 : 8'h00);
      check(8'(irq), 8'(e[1]), "irq rise");
      wr(CMPX_ADR_STATUS, 8'h03);
      check(8'(irq), 8'h00, "irq clear");
      v_pin <= 16'h1010;
      tick(5);
      rd(CMPX_ADR_STATUS, e[0] ? 8'h03 : 8'h00);
      check(8'(irq), 8'(e[0]), "irq fall");
    end
    // clear lands on the very edge that a new rise sets the flags
    wr(CMPX_ADR_STATUS, 8'h03);
    v_pin <= 16'hf0f0;
    tick(2);
    wr(CMPX_ADR_STATUS, 8'h03);
    rd(CMPX_ADR_STATUS, 8'h03);
    // only the masked second flag left standing
    wr(CMPX_ADR_STATUS, 8'h01);
    check(8'(irq), 8'h00, "irq masked");
    wr(CMPX_ADR_MASK, 8'h02);
    check(8'(irq), 8'h01, "irq unmasked");
    rd(CMPX_ADR_MASK, 8'h02);
    rd(CMPX_ADR_STATUS, 8'h02);
    test_done();
  end
endmodule
